// File: hdl/cvd_defs.svh
// Register offsets, field positions, reset values and timing counts of the converter control
// ***************************************************************************
// ***************************************************************************
`ifndef CVD_DEFS_SVH
`define CVD_DEFS_SVH
`define CVD_A_RES0L_LO 12'h009b
`define CVD_A_RES0H_LO 12'h009c
`define CVD_A_CTL0_LO 12'h009d
`define CVD_A_CTL1_LO 12'h009e
`define CVD_A_CTL2_LO 12'h009f
`define CVD_A_CTL0 12'h0711
`define CVD_A_CTL1 12'h0712
`define CVD_A_CTL2 12'h0713
`define CVD_A_CTL3 12'h0714
`define CVD_A_STAT 12'h0715
`define CVD_A_PRE 12'h0716
`define CVD_A_ACQ 12'h0717
`define CVD_A_GRD 12'h0718
`define CVD_A_CAP 12'h0719
`define CVD_A_RES0L 12'h071a
`define CVD_A_RES0H 12'h071b
`define CVD_A_RES1L 12'h071c
`define CVD_A_RES1H 12'h071d
`define CVD_CTL0_MASK 8'h7f
`define CVD_CTL1_MASK 8'hf3
`define CVD_CTL2_MASK 8'h70
`define CVD_CTL3_MASK 8'hdb
`define CVD_PRE_MASK 8'h7f
`define CVD_GRD_MASK 8'he0
`define CVD_CAP_MASK 8'h07
`define CVD_RST_VAL 8'h00
`define CVD_TRIG_TIMER_ZERO 3'h3
`define CVD_GAP_CYCLES 2
`define CVD_CONV_TADS 11
`endif

// File: hdl/cvd_pkg.sv
// Types shared by the converter control block
`default_nettype none
package cvd_pkg;
   // Processor side register access
   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [7:0] wdata;
   } cvd_bus_t;
   // Analog front end sequencing and selections
   typedef struct packed {
      logic power_on;
      logic [7:0] channel_onehot;
      logic [1:0] ref_sel;
      logic rc_clock_sel;
      logic [1:0] stage;
      logic second_conv;
      logic invert_pol;
   } cvd_ana_t;
   typedef enum logic [1:0] {
      CVD_REF_SUPPLY,
      CVD_REF_RESERVED,
      CVD_REF_PIN,
      CVD_REF_FIXED
   } cvd_ref_t;
endpackage : cvd_pkg
`default_nettype wire

// File: hdl/cvd_adc_control_regs.sv
// Banked register file and conversion sequencer of the divider enhanced converter
`include "cvd_defs.svh"
`default_nettype none
module cvd_adc_control_regs #(
   parameter int unsigned RES_BITS = 10,
   parameter int unsigned GAP_CYCLES = `CVD_GAP_CYCLES
) (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic clk_en_i,
   input wire cvd_pkg::cvd_bus_t bus_i,
   output logic [7:0] rdata_o,
   input wire logic conv_tick_i,
   input wire logic rc_tick_i,
   input wire logic [RES_BITS-1:0] sample_i,
   input wire logic timer_zero_ovf_i,
   output cvd_pkg::cvd_ana_t ana_o,
   output logic conv_done_o
);
   import cvd_pkg::*;

   // Elaboration checks: the formatter is built for ten bits and the gap counter has eight
   if (RES_BITS != 10) begin : g_bad_res
      $error("Result width must be 10");
   end
   if (GAP_CYCLES < 1 || GAP_CYCLES > 256) begin : g_bad_gap
      $error("Gap must be 1 to 256 cycles");
   end

   typedef enum logic [2:0] {CVD_IDLE, CVD_PRE, CVD_ACQ, CVD_CONV, CVD_GAP} cvd_state_t;

   // ***************************************************************************
   // Register file
   // ***************************************************************************
   logic [7:0] ctl0_ff, ctl1_ff, ctl2_ff, ctl3_ff, pre_ff, acq_ff, grd_ff, cap_ff;
   logic [7:0] res0l_ff, res0h_ff, res1l_ff, res1h_ff;
   logic [7:0] nxt_ctl0, nxt_ctl1, nxt_ctl2, nxt_ctl3, nxt_pre, nxt_acq, nxt_grd, nxt_cap;
   logic [7:0] nxt_res0l, nxt_res0h, nxt_res1l, nxt_res1h;
   logic [7:0] rdata_ff, nxt_rdata;
   cvd_state_t state_ff, nxt_state;
   logic [7:0] cnt_ff, nxt_cnt;
   logic second_ff, nxt_second;
   logic done_ff, nxt_done;
   logic trig_s1_ff, trig_s2_ff, trig_prev_ff;
   logic [RES_BITS-1:0] samp_s1_ff, samp_s2_ff;
   cvd_ana_t ana_ff, nxt_ana;

   // Address decode, both banks steer the same storage so aliases are coherent
   logic sel_ctl0, sel_ctl1, sel_ctl2, sel_res0l, sel_res0h;
   assign sel_ctl0 = (bus_i.addr == `CVD_A_CTL0) || (bus_i.addr == `CVD_A_CTL0_LO);
   assign sel_ctl1 = (bus_i.addr == `CVD_A_CTL1) || (bus_i.addr == `CVD_A_CTL1_LO);
   assign sel_ctl2 = (bus_i.addr == `CVD_A_CTL2) || (bus_i.addr == `CVD_A_CTL2_LO);
   assign sel_res0l = (bus_i.addr == `CVD_A_RES0L) || (bus_i.addr == `CVD_A_RES0L_LO);
   assign sel_res0h = (bus_i.addr == `CVD_A_RES0H) || (bus_i.addr == `CVD_A_RES0H_LO);

   // Trigger source is the overflow that also sets the timer's own flag; pin-like, so synced
   logic trig_edge, sw_start, start_ok, busy, trig_en;
   assign trig_en = (ctl2_ff[6:4] == `CVD_TRIG_TIMER_ZERO);
   assign trig_edge = trig_en && trig_s2_ff && !trig_prev_ff;
   assign busy = (state_ff != CVD_IDLE);
   assign sw_start = bus_i.wr && sel_ctl0 && bus_i.wdata[1] && !ctl0_ff[1];
   assign start_ok = ctl0_ff[0] && !busy && (sw_start || trig_edge);

   // Result formatting: one shared path for both result pairs
   logic [15:0] fmt_res;
   always_comb begin
      if (ctl1_ff[7]) begin
         fmt_res = {6'h00, samp_s2_ff};
      end else begin
         fmt_res = {samp_s2_ff, 6'h00};
      end
   end

   // Stage timing tick: RC clock ticks when the dedicated RC clock is chosen
   logic rc_sel, tick;
   assign rc_sel = (ctl1_ff[5:4] == 2'b11);
   assign tick = rc_sel ? rc_tick_i : conv_tick_i;

   // Register write and conversion sequencer next state
   always_comb begin
      nxt_ctl0 = ctl0_ff;
      nxt_ctl1 = ctl1_ff;
      nxt_ctl2 = ctl2_ff;
      nxt_ctl3 = ctl3_ff;
      nxt_pre = pre_ff;
      nxt_acq = acq_ff;
      nxt_grd = grd_ff;
      nxt_cap = cap_ff;
      nxt_res0l = res0l_ff;
      nxt_res0h = res0h_ff;
      nxt_res1l = res1l_ff;
      nxt_res1h = res1h_ff;
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_second = second_ff;
      nxt_done = 1'b0;
      if (bus_i.wr) begin
         // Start bit is kept by hardware while busy; software cannot abort here
         if (sel_ctl0) nxt_ctl0 = (bus_i.wdata & `CVD_CTL0_MASK & 8'hfd) | {6'h00, ctl0_ff[1], 1'b0};
         if (sel_ctl1) nxt_ctl1 = bus_i.wdata & `CVD_CTL1_MASK;
         if (sel_ctl2) nxt_ctl2 = bus_i.wdata & `CVD_CTL2_MASK;
         if (bus_i.addr == `CVD_A_CTL3) nxt_ctl3 = bus_i.wdata & `CVD_CTL3_MASK;
         if (bus_i.addr == `CVD_A_PRE) nxt_pre = bus_i.wdata & `CVD_PRE_MASK;
         if (bus_i.addr == `CVD_A_ACQ) nxt_acq = bus_i.wdata & `CVD_PRE_MASK;
         if (bus_i.addr == `CVD_A_GRD) nxt_grd = bus_i.wdata & `CVD_GRD_MASK;
         if (bus_i.addr == `CVD_A_CAP) nxt_cap = bus_i.wdata & `CVD_CAP_MASK;
         if (sel_res0l) nxt_res0l = bus_i.wdata;
         if (sel_res0h) nxt_res0h = bus_i.wdata;
         if (bus_i.addr == `CVD_A_RES1L) nxt_res1l = bus_i.wdata;
         if (bus_i.addr == `CVD_A_RES1H) nxt_res1h = bus_i.wdata;
      end
      unique case (state_ff)
         CVD_IDLE: begin
            if (start_ok) begin
               nxt_ctl0[1] = 1'b1;
               nxt_second = 1'b0;
               nxt_state = CVD_PRE;
               nxt_cnt = 8'h00;
            end
         end
         CVD_PRE: begin
            if (cnt_ff >= pre_ff) begin
               nxt_state = CVD_ACQ;
               nxt_cnt = 8'h00;
            end else if (tick) begin
               nxt_cnt = cnt_ff + 8'h01;
            end
         end
         CVD_ACQ: begin
            if (cnt_ff >= acq_ff) begin
               nxt_state = CVD_CONV;
               nxt_cnt = 8'h00;
            end else if (tick) begin
               nxt_cnt = cnt_ff + 8'h01;
            end
         end
         CVD_CONV: begin
            if (cnt_ff == 8'(`CVD_CONV_TADS)) begin
               nxt_cnt = 8'h00;
               nxt_done = !ctl3_ff[0] || second_ff;
               if (second_ff) begin
                  nxt_res1l = fmt_res[7:0];
                  nxt_res1h = fmt_res[15:8];
               end else begin
                  nxt_res0l = fmt_res[7:0];
                  nxt_res0h = fmt_res[15:8];
               end
               if (ctl3_ff[0] && !second_ff) begin
                  nxt_state = CVD_GAP;
               end else begin
                  nxt_state = CVD_IDLE;
                  nxt_ctl0[1] = 1'b0;
               end
            end else if (tick) begin
               nxt_cnt = cnt_ff + 8'h01;
            end
         end
         CVD_GAP: begin
            if (cnt_ff == 8'(GAP_CYCLES - 1)) begin
               nxt_state = CVD_PRE;
               nxt_second = 1'b1;
               nxt_cnt = 8'h00;
            end else begin
               nxt_cnt = cnt_ff + 8'h01;
            end
         end
      endcase
      // Turning the converter off abandons any sequence in flight
      if (!nxt_ctl0[0]) begin
         nxt_state = CVD_IDLE;
         nxt_ctl0[1] = 1'b0;
         nxt_second = 1'b0;
      end
   end

   // Read mux, unmapped addresses read zero
   always_comb begin
      nxt_rdata = 8'h00;
      if (bus_i.rd) begin
         if (sel_ctl0) nxt_rdata = ctl0_ff;
         else if (sel_ctl1) nxt_rdata = ctl1_ff;
         else if (sel_ctl2) nxt_rdata = ctl2_ff;
         else if (sel_res0l) nxt_rdata = res0l_ff;
         else if (sel_res0h) nxt_rdata = res0h_ff;
         else if (bus_i.addr == `CVD_A_CTL3) nxt_rdata = ctl3_ff;
         else if (bus_i.addr == `CVD_A_STAT) nxt_rdata = {5'h00, ana_ff.second_conv, ana_ff.stage};
         else if (bus_i.addr == `CVD_A_PRE) nxt_rdata = pre_ff;
         else if (bus_i.addr == `CVD_A_ACQ) nxt_rdata = acq_ff;
         else if (bus_i.addr == `CVD_A_GRD) nxt_rdata = grd_ff;
         else if (bus_i.addr == `CVD_A_CAP) nxt_rdata = cap_ff;
         else if (bus_i.addr == `CVD_A_RES1L) nxt_rdata = res1l_ff;
         else if (bus_i.addr == `CVD_A_RES1H) nxt_rdata = res1h_ff;
      end
   end

   // Analog side selections and stage indication
   always_comb begin
      nxt_ana = '0;
      nxt_ana.power_on = nxt_ctl0[0];
      unique case (nxt_ctl0[6:2])
         5'h00, 5'h01, 5'h02, 5'h03, 5'h04:
            nxt_ana.channel_onehot = 8'(1) << nxt_ctl0[4:2];
         5'h1a: nxt_ana.channel_onehot = 8'h20;
         5'h1d: nxt_ana.channel_onehot = 8'h40;
         5'h1f: nxt_ana.channel_onehot = 8'h80;
         default: nxt_ana.channel_onehot = 8'h00;
      endcase
      // Reserved reference code leaves the reference on the supply
      nxt_ana.ref_sel = (nxt_ctl1[1:0] == 2'b01) ? 2'b00 : nxt_ctl1[1:0];
      nxt_ana.rc_clock_sel = (nxt_ctl1[5:4] == 2'b11);
      unique case (nxt_state)
         CVD_PRE: nxt_ana.stage = 2'b01;
         CVD_ACQ: nxt_ana.stage = 2'b10;
         CVD_CONV: nxt_ana.stage = 2'b11;
         default: nxt_ana.stage = 2'b00;
      endcase
      nxt_ana.second_conv = nxt_second && (nxt_state != CVD_IDLE);
      nxt_ana.invert_pol = nxt_ana.second_conv && nxt_ctl3[1];
   end

   // State registers: all frozen while the clock enable is low
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         ctl0_ff <= `CVD_RST_VAL;
         ctl1_ff <= `CVD_RST_VAL;
         ctl2_ff <= `CVD_RST_VAL;
         ctl3_ff <= `CVD_RST_VAL;
         pre_ff <= `CVD_RST_VAL;
         acq_ff <= `CVD_RST_VAL;
         grd_ff <= `CVD_RST_VAL;
         cap_ff <= `CVD_RST_VAL;
         res0l_ff <= `CVD_RST_VAL;
         res0h_ff <= `CVD_RST_VAL;
         res1l_ff <= `CVD_RST_VAL;
         res1h_ff <= `CVD_RST_VAL;
         rdata_ff <= `CVD_RST_VAL;
         state_ff <= CVD_IDLE;
         cnt_ff <= 8'h00;
         second_ff <= 1'b0;
         done_ff <= 1'b0;
         trig_s1_ff <= 1'b0;
         trig_s2_ff <= 1'b0;
         trig_prev_ff <= 1'b0;
         samp_s1_ff <= '0;
         samp_s2_ff <= '0;
         ana_ff <= '0;
      end else if (clk_en_i) begin
         ctl0_ff <= nxt_ctl0;
         ctl1_ff <= nxt_ctl1;
         ctl2_ff <= nxt_ctl2;
         ctl3_ff <= nxt_ctl3;
         pre_ff <= nxt_pre;
         acq_ff <= nxt_acq;
         grd_ff <= nxt_grd;
         cap_ff <= nxt_cap;
         res0l_ff <= nxt_res0l;
         res0h_ff <= nxt_res0h;
         res1l_ff <= nxt_res1l;
         res1h_ff <= nxt_res1h;
         rdata_ff <= nxt_rdata;
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         second_ff <= nxt_second;
         done_ff <= nxt_done;
         trig_s1_ff <= timer_zero_ovf_i;
         trig_s2_ff <= trig_s1_ff;
         trig_prev_ff <= trig_s2_ff;
         samp_s1_ff <= sample_i;
         samp_s2_ff <= samp_s1_ff;
         ana_ff <= nxt_ana;
      end
   end

   assign rdata_o = rdata_ff;
   assign ana_o = ana_ff;
   assign conv_done_o = done_ff;

   // ***************************************************************************
   // Checks
   // ***************************************************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);

   sequence s_first_done;
      clk_en_i && state_ff == CVD_CONV && nxt_state == CVD_GAP;
   endsequence

   // Bank aliases share storage, so a low bank write shows at once
   a_alias_ctl0: assert property (clk_en_i && bus_i.wr && bus_i.addr == `CVD_A_CTL0_LO
      && bus_i.wdata[0] |=> ctl0_ff[0]) else $error("alias write lost");
   a_ctl_unimpl: assert property (ctl0_ff[7] == 1'b0 && ctl1_ff[3:2] == 2'b00
      && ctl2_ff[3:0] == 4'h0 && ctl2_ff[7] == 1'b0) else $error("unimpl bit set");

   // Reset leaves every implemented control field at zero
   a_ctl_reset: assert property ($fell(srst_i) |-> ctl0_ff == 8'h00
      && ctl1_ff == 8'h00 && ctl2_ff == 8'h00) else $error("control not reset");

   // A start that survives the enable write enters pre-charge with the status bit up
   a_start_sets: assert property (clk_en_i && start_ok && nxt_ctl0[0] |=> ctl0_ff[1]
      && state_ff == CVD_PRE) else $error("start not taken");
   a_busy_holds: assert property (state_ff != CVD_IDLE |-> ctl0_ff[1])
      else $error("status dropped while busy");
   // The completion pulse comes with the status bit already cleared
   a_done_idle: assert property (done_ff |-> state_ff == CVD_IDLE && !ctl0_ff[1])
      else $error("done while busy");
   a_off_idle: assert property (!ctl0_ff[0] |-> state_ff == CVD_IDLE && !ctl0_ff[1])
      else $error("running while disabled");
   a_gap_two: assert property (s_first_done ##1 (clk_en_i [*2]) |=> state_ff == CVD_PRE
      && second_ff) else $error("second conversion gap wrong");

   // A first conversion never touches the second result pair
   a_res1_keep: assert property (clk_en_i && busy && !second_ff && !bus_i.wr
      |=> $stable(res1l_ff) && $stable(res1h_ff)) else $error("second pair overwritten");
   a_single_end: assert property (clk_en_i && state_ff == CVD_CONV
      && nxt_state != CVD_CONV && !ctl3_ff[0] |=> state_ff == CVD_IDLE)
      else $error("extra conversion");
   a_right_just: assert property (clk_en_i && state_ff == CVD_CONV
      && nxt_state == CVD_IDLE && ctl1_ff[7] && !second_ff |=> res0h_ff[7:2] == 6'h00)
      else $error("right justify wrong");
   a_left_just: assert property (clk_en_i && state_ff == CVD_CONV
      && nxt_state != CVD_CONV && ctl0_ff[0] && !ctl1_ff[7] && !second_ff
      |=> res0l_ff[5:0] == 6'h00) else $error("left justify wrong");

   // Apart from a control write, only a fresh rising edge of the synced overflow may start a sequence
   a_trig_off: assert property (ctl2_ff[6:4] != `CVD_TRIG_TIMER_ZERO && state_ff == CVD_IDLE
      && !(bus_i.wr && sel_ctl0) |=> state_ff == CVD_IDLE)
      else $error("trigger with source off");
   a_trig_start: assert property (clk_en_i && ctl2_ff[6:4] == `CVD_TRIG_TIMER_ZERO
      && trig_s2_ff && !trig_prev_ff && ctl0_ff[0] && state_ff == CVD_IDLE
      && !(bus_i.wr && sel_ctl0) |=> state_ff == CVD_PRE) else $error("trigger edge lost");
   a_trig_level: assert property (clk_en_i && trig_s2_ff && trig_prev_ff
      && state_ff == CVD_IDLE && !(bus_i.wr && sel_ctl0) |=> state_ff == CVD_IDLE)
      else $error("held trigger restarted");

   // Output side selections follow the registers they are decoded from
   a_power_out: assert property (ana_ff.power_on == ctl0_ff[0])
      else $error("power output wrong");
   a_chan_none: assert property (ctl0_ff[6:2] > 5'h04
      && !(ctl0_ff[6:2] inside {5'h1a, 5'h1d, 5'h1f}) |-> ana_ff.channel_onehot == 8'h00)
      else $error("reserved channel connected");
   a_ref_reserved: assert property (ctl1_ff[1:0] == 2'b01 |-> ana_ff.ref_sel == 2'b00)
      else $error("reserved reference routed");
endmodule : cvd_adc_control_regs
`default_nettype wire

// File: verification/cvd_afe_model.sv
// Analog front end stand-in: conversion clock ticks and the converted level
`default_nettype none
module cvd_afe_model (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic [9:0] level_i,
   output logic conv_tick_o,
   output logic rc_tick_o,
   output logic [9:0] sample_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] div_ff;
   // Free running divider behind both tick outputs
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         div_ff <= 2'h0;
      end else begin
         div_ff <= div_ff + 2'h1;
      end
   end
   // RC tick runs at a different rate so a wrong clock choice changes timing
   assign conv_tick_o = div_ff[0];
   assign rc_tick_o = (div_ff == 2'h2);
   // Converter output follows the measured level
   assign sample_o = level_i;
endmodule // cvd_afe_model
`default_nettype wire

// File: verification/tb_cvd_adc_control_regs.sv
// Self-checking bench of the converter control register block
`include "cvd_defs.svh"
`default_nettype none
module tb_cvd_adc_control_regs;
   timeunit 1ns;
   timeprecision 100ps;
   import cvd_pkg::*;
   logic clock_i, srst_i, clk_en_i, ovf, conv_tick, rc_tick, done, have1;
   cvd_bus_t bus;
   cvd_ana_t ana;
   logic [7:0] rdata;
   logic [9:0] sample, level;
   logic [7:0] m[4];
   logic [7:0] masks[3] = '{8'h7f, 8'hf3, 8'h70};
   logic [7:0] ext_mask[6] = '{8'hdb, 8'h00, 8'h7f, 8'h7f, 8'he0, 8'h07};
   logic [7:0] ref_exp[4] = '{8'h00, 8'h00, 8'h02, 8'h03};
   int fail_count, compares, seed;
   // ***************************************************************************
   // Clock and instances
   // ***************************************************************************
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   cvd_afe_model afe (.clock_i(clock_i), .srst_i(srst_i), .level_i(level),
      .conv_tick_o(conv_tick), .rc_tick_o(rc_tick), .sample_o(sample));
   cvd_adc_control_regs uut (.clock_i(clock_i), .srst_i(srst_i), .clk_en_i(clk_en_i),
      .bus_i(bus), .rdata_o(rdata), .conv_tick_i(conv_tick), .rc_tick_i(rc_tick),
      .sample_i(sample), .timer_zero_ovf_i(ovf), .ana_o(ana), .conv_done_o(done));
   // ***************************************************************************
   // Model and bus tasks
   // ***************************************************************************
   // Expected one-hot routing of a channel code
   function automatic logic [7:0] chan_exp(input int code);
      if (code < 5) return 8'(1 << code);
      if (code == 26) return 8'h20;
      if (code == 29) return 8'h40;
      if (code == 31) return 8'h80;
      return 8'h00;
   endfunction
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clock_i) #1;
      bus.wr = 1'b1;
      bus.addr = a;
      bus.wdata = d;
      @(posedge clock_i) #1;
      bus.wr = 1'b0;
   endtask
   // Read data stands only the cycle after the strobe, so it is taken there
   task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] exp);
      @(posedge clock_i) #1;
      bus.rd = 1'b1;
      bus.addr = a;
      @(posedge clock_i) #1;
      bus.rd = 1'b0;
      chk(what, exp, rdata);
   endtask
   task automatic reg_zero();
      for (int i = 0; i < 3; i++) begin
         rd_chk("ctl low reset", 12'(`CVD_A_CTL0_LO + i), 8'h00);
         rd_chk("ctl high reset", 12'(`CVD_A_CTL0 + i), 8'h00);
      end
   endtask
   // Bounded wait, since a hung sequencer must not stall the run
   task automatic wait_done(input string what);
      int n;
      n = 0;
      while (done !== 1'b1 && n < 3000) begin
         @(posedge clock_i) #1;
         n++;
      end
      chk(what, 8'h01, {7'h00, done});
   endtask
   task automatic no_done(input string what);
      int k;
      k = 0;
      repeat (120) begin
         @(posedge clock_i) #1;
         if (done === 1'b1) k++;
      end
      chk(what, 8'h00, 8'(k));
   endtask
   task automatic run_conv(input logic fmt, input logic dbl, input logic [2:0] cs);
      logic [9:0] s;
      int n;
      s = 10'($random(seed));
      n = 0;
      level = s;
      m[0] = fmt ? s[7:0] : {s[1:0], 6'h00};
      m[1] = fmt ? {6'h00, s[9:8]} : s[9:2];
      if (dbl) begin
         m[2] = m[0];
         m[3] = m[1];
         have1 = 1'b1;
      end
      wr(`CVD_A_CTL3, {6'h00, dbl, dbl});
      wr(`CVD_A_CTL1, {fmt, cs, 4'h0});
      // Enable first: a start bit written together with the enable is not taken
      wr(`CVD_A_CTL0_LO, 8'h01);
      wr(`CVD_A_CTL0_LO, 8'h03);
      rd_chk("busy", `CVD_A_CTL0, 8'h03);
      chk("stage", 8'h01, {6'h00, ana.stage});
      if (dbl) begin
         while (ana.second_conv !== 1'b1 && n < 3000) begin
            @(posedge clock_i) #1;
            n++;
         end
         chk("second invert", 8'h03, {6'h00, ana.second_conv, ana.invert_pol});
      end
      wait_done("done");
      rd_chk("idle", `CVD_A_CTL0, 8'h01);
      for (int k = 0; k < 4; k++) begin
         if (k < 2 || have1) rd_chk("result", 12'(`CVD_A_RES0L + k), m[k]);
      end
      rd_chk("result low alias", `CVD_A_RES0L_LO, m[0]);
      rd_chk("result high alias", `CVD_A_RES0H_LO, m[1]);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ***************************************************************************
   // Scenarios
   // ***************************************************************************
   initial begin
      logic [7:0] d;
      seed = 86713;
      fail_count = 0;
      compares = 0;
      have1 = 1'b0;
      srst_i = 1'b1;
      clk_en_i = 1'b1;
      ovf = 1'b0;
      bus = '0;
      level = '0;
      repeat (2) @(posedge clock_i);
      #1 srst_i = 1'b0;
      reg_zero();
      // Writes through one bank show in the other, start bit kept clear
      for (int i = 0; i < 3; i++) begin
         d = 8'($random(seed)) & 8'hfd;
         wr(12'(`CVD_A_CTL0_LO + i), d);
         rd_chk("ctl high", 12'(`CVD_A_CTL0 + i), d & masks[i]);
         d = ~d & 8'hfd;
         wr(12'(`CVD_A_CTL0 + i), d);
         rd_chk("ctl low", 12'(`CVD_A_CTL0_LO + i), d & masks[i]);
      end
      @(posedge clock_i) #1 srst_i = 1'b1;
      repeat (2) @(posedge clock_i);
      #1 srst_i = 1'b0;
      reg_zero();
      for (int i = 0; i < 6; i++) begin
         wr(12'(`CVD_A_CTL3 + i), 8'hff);
         rd_chk("extended", 12'(`CVD_A_CTL3 + i), ext_mask[i]);
         wr(12'(`CVD_A_CTL3 + i), 8'h00);
      end
      rd_chk("unmapped", 12'h720, 8'h00);
      for (int i = 0; i < 32; i++) begin
         wr(`CVD_A_CTL0, 8'((i << 2) | 1));
         repeat (2) @(posedge clock_i) #1;
         chk("channel", chan_exp(i), ana.channel_onehot);
         chk("power", 8'h01, {7'h00, ana.power_on});
      end
      wr(`CVD_A_CTL0, 8'h00);
      repeat (2) @(posedge clock_i) #1;
      chk("power off", 8'h00, {7'h00, ana.power_on});
      for (int i = 0; i < 32; i++) begin
         wr(`CVD_A_CTL1_LO, 8'(((i >> 2) << 4) | (i & 3)));
         repeat (2) @(posedge clock_i) #1;
         chk("reference", ref_exp[i & 3], {6'h00, ana.ref_sel});
         chk("rc clock", 8'(((i >> 2) & 3) == 3), {7'h00, ana.rc_clock_sel});
      end
      wr(`CVD_A_PRE, 8'h02);
      wr(`CVD_A_ACQ, 8'h03);
      run_conv(1'b0, 1'b1, 3'h7);
      run_conv(1'b1, 1'b0, 3'h0);
      run_conv(1'b0, 1'b0, 3'h5);
      run_conv(1'b1, 1'b1, 3'h3);
      // Timer overflow starts one conversion sequence per rising edge only
      wr(`CVD_A_CTL2, 8'h30);
      @(posedge clock_i) #1 ovf = 1'b1;
      wait_done("trigger start");
      no_done("held trigger");
      ovf = 1'b0;
      wr(`CVD_A_CTL2, 8'h20);
      @(posedge clock_i) #1 ovf = 1'b1;
      no_done("reserved trigger");
      ovf = 1'b0;
      // A write while the clock enable is low must not land
      clk_en_i = 1'b0;
      wr(`CVD_A_CTL2, 8'h50);
      clk_en_i = 1'b1;
      rd_chk("frozen write", `CVD_A_CTL2, 8'h20);
      wr(`CVD_A_CTL0, 8'h00);
      wr(`CVD_A_CTL0, 8'h02);
      no_done("disabled start");
      rd_chk("disabled status", `CVD_A_CTL0, 8'h00);
      conclude();
   end
   // Whole run needs well under this span
   initial begin
      #500000;
      fail_count++;
      conclude();
   end
endmodule // tb_cvd_adc_control_regs
`default_nettype wire
